// file: tb_top.sv
// Self-checking bench for the timer: registers, periods, scalers, interrupt, pin counting.
// Drives tc_timer over AHB-Lite, hready fed from hreadyout, mclk at 100 MHz.
`timescale 1ns/1ps
module tb_top;
	localparam logic [7:0] LO = tc_pkg::OFS_COUNT_LOW;
	localparam logic [7:0] HI = tc_pkg::OFS_COUNT_HIGH;
	localparam logic [7:0] C0 = tc_pkg::OFS_CONFIG_ZERO;
	localparam logic [7:0] C1 = tc_pkg::OFS_CONFIG_ONE;
	localparam logic [7:0] ST = tc_pkg::OFS_INT_STATUS;
	localparam logic [7:0] MK = tc_pkg::OFS_INT_MASK;
	logic        mclk, reset, hsel, hwrite, tmr_clk_pin, sleep_mode;
	logic        hreadyout, hresp, timer_output_pulse, irq;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	wire         hready = hreadyout;
	int          failures, n_tests;
	int          seed = 32'h941d9e8e;
	logic [7:0]  per_cfg [4] = '{8'h70, 8'h73, 8'h42, 8'h40};
	logic [7:0]  pin_cfg [4] = '{8'h10, 8'h30, 8'h90, 8'h60};

	tc_timer i_dut (.mclk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
		.hreadyout, .hresp, .tmr_clk_pin, .sleep_mode, .timer_output_pulse, .irq);

	// Clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Counter tick length in mclk cycles for a config one value
	function automatic int tick(logic [7:0] c);
		return (c[7:5] == tc_pkg::CS_SYSTEM ? 1 : tc_pkg::INSTR_DIV) << c[3:0];
	endfunction

	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask

	// One single transfer: address phase, then data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		hwrite <= w;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		do @(posedge mclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge mclk); while (hready !== 1'b1);
		r = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask

	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		cmp(nm, e, r);
	endtask

	// Sixteen-bit read: low first, then buffered high
	task automatic rd16(output logic [31:0] r);
		logic [31:0] l, h;
		bus(1'b0, LO, 32'h0, l);
		bus(1'b0, HI, 32'h0, h);
		r = {16'h0, h[7:0], l[7:0]};
	endtask

	// Pulse width and pulse-to-pulse interval in cycles
	task automatic per(output int iv, output int wd);
		time t0;
		@(posedge timer_output_pulse);
		t0 = $time;
		@(negedge timer_output_pulse);
		wd = ($time - t0) / 10;
		@(posedge timer_output_pulse);
		iv = ($time - t0) / 10;
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Cut a hang short
	initial begin
		repeat (60000) @(posedge mclk);
		failures++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		logic [31:0] r, v;
		int          p, k, n, iv, wd;
		{hwrite, htrans, haddr, hwdata, tmr_clk_pin, sleep_mode} = '0;
		hsel = 1'b1;
		hsize = 3'h2;
		reset = 1'b1;
		repeat (12) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		// Reset state, direct access in 8-bit width, unmapped hole
		rd("low_rst", LO, 32'h0);
		rd("high_rst", HI, 32'hff);
		rd("unmapped", 8'h18, 32'h0);
		v = $random(seed) & 8'hff;
		wr(HI, v);
		rd("high_rw", HI, v);
		v = $random(seed) & 8'hff;
		wr(LO, v);
		rd("low_rw", LO, v);
		// Period match across sources, prescale ratios and sync modes
		p = 8 + ($random(seed) & 7);
		wr(HI, p);
		wr(C0, 32'h80);
		for (int i = 0; i < 4; i++) begin
			wr(C1, per_cfg[i]);
			per(iv, wd);
			cmp("interval", (p + 1) * tick(per_cfg[i]), iv);
			cmp("width", tick(per_cfg[i]), wd);
		end
		// Postscaler feeds the flag, mask gates irq, read clears
		n = 1 + ($random(seed) & 3);
		wr(MK, 32'h1);
		wr(C1, 32'h73);
		wr(C0, 32'h80 | (n - 1));
		wr(LO, 32'h0);
		bus(1'b0, ST, 32'h0, r);
		for (int i = 1; i <= n; i++) begin
			@(posedge timer_output_pulse);
			repeat (3) @(posedge mclk);
			cmp("irq", i == n, irq);
		end
		wr(MK, 32'h0);
		@(posedge mclk);
		cmp("irq_masked", 32'h0, irq);
		rd("status", ST, 32'h1);
		rd("status_clr", ST, 32'h0);
		// Sixteen-bit coherent read, rollover, buffered high write
		wr(C1, 32'h70);
		wr(C0, 32'h90);
		bus(1'b0, ST, 32'h0, r);
		v = 8'hf0 | ($random(seed) & 3);
		wr(HI, 32'hff);
		wr(LO, v);
		rd16(r);
		cmp("coherent", 32'h1, (r - {8'hff, v[7:0]}) inside {[1:8]});
		@(posedge timer_output_pulse);
		rd("wrap_flag", ST, 32'h1);
		wr(HI, 32'h55);
		rd("high_buf", HI, 32'h55);
		rd16(r);
		cmp("live_high", 32'h0, r[15:8]);
		// The low read above refilled the buffer with the live high byte
		wr(HI, 32'h55);
		wr(LO, 32'h0);
		rd16(r);
		cmp("loaded_high", 32'h55, r[15:8]);
		// Pin edges counted asleep in async mode; idle sources stay put
		k = 1 + ($random(seed) & 3);
		wr(C0, 32'h80);
		sleep_mode <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr(C1, pin_cfg[i]);
			wr(LO, 32'h0);
			repeat (k) begin
				tmr_clk_pin <= 1'b1;
				repeat (8) @(posedge mclk);
				tmr_clk_pin <= 1'b0;
				repeat (8) @(posedge mclk);
			end
			rd("pin_count", LO, i < 2 ? k : 0);
		end
		sleep_mode <= 1'b0;
		// Reset in mid-run restores the count registers
		reset <= 1'b1;
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		rd("low_rst2", LO, 32'h0);
		rd("high_rst2", HI, 32'hff);
		tally_and_finish();
	end
endmodule // tb_top

// file: tc_pkg.sv
// Constants shared by the 8/16-bit timer/counter: register map, fields, reset values, timing.
// Assumes an AHB-Lite register bus with 32-bit data and a 100 MHz mclk.
//
// Contract
// - One configuration bit picks 8-bit or 16-bit counting.
// - 16-bit: high and low bytes advance together after a 15-bit prescaler.
// - 16-bit: reading the low byte copies the live high byte to the buffer.
// - 16-bit: high writes go to the buffer; low write loads live high.
// - 8-bit: low byte advances per prescaled tick, compared with the period buffer.
// - 8-bit match: one-period output pulse, low cleared, period buffer reloaded.
// - 8-bit: low and high registers are read and written directly.
// - Reset clears the low byte and sets the high register to all ones.
// - Scalers clear on low write, configuration write, and any reset.
// - Counter mode steps per input edge; prescale select zero bypasses prescaler.
// - Timer mode steps once per instruction cycle, slower with prescaling; the code's CS_SYSTEM source in async mode steps once per mclk.
// - Async select: steps on raw prescaled edges, keeps counting pin edges during sleep.
// - Sync select: steps aligned to the quarter-rate instruction cycle.
// - High register is the period in 8-bit, the upper count byte in 16-bit.
// - Three-bit clock source select picks internal or external timer clock.

package tc_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_COUNT_LOW   = 8'h00;
	localparam logic [7:0] OFS_COUNT_HIGH  = 8'h04;
	localparam logic [7:0] OFS_CONFIG_ZERO = 8'h08;
	localparam logic [7:0] OFS_CONFIG_ONE  = 8'h0c;
	localparam logic [7:0] OFS_INT_STATUS  = 8'h10;
	localparam logic [7:0] OFS_INT_MASK    = 8'h14;

	// Field positions in timer_config_zero
	localparam int CZ_ENABLE_BIT = 7;
	localparam int CZ_OUTPUT_BIT = 5;
	localparam int CZ_WIDE_BIT   = 4;
	// Field positions in timer_config_one
	localparam int CO_ASYNC_BIT  = 4;
	localparam int CO_CSEL_LSB   = 5;

	// Reset values
	localparam logic [7:0] RST_COUNT_LOW  = 8'h00;
	localparam logic [7:0] RST_COUNT_HIGH = 8'hff;
	localparam logic [7:0] RST_CONFIG     = 8'h00;

	// Clock source select codes
	localparam logic [2:0] CS_PIN_RISE = 3'h0;
	localparam logic [2:0] CS_PIN_FALL = 3'h1;
	localparam logic [2:0] CS_INSTR    = 3'h2;
	localparam logic [2:0] CS_SYSTEM   = 3'h3;

	// Widths of the scalers
	localparam int PRESCALE_W  = 15;
	localparam int POSTSCALE_W = 4;

	// Instruction cycle is one quarter of the system clock
	localparam int SYS_CLK_MHZ     = 100;
	localparam int INSTR_DIV       = 4;
	localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);

	// Bus access phases
	typedef enum logic [1:0] {
		BUS_IDLE   = 2'b01,
		BUS_ACCESS = 2'b10
	} tc_bus_st_t;

endpackage

// file: tc_scaler.sv
// Wrap-around event scaler used as prescaler and postscaler.
// Assumes step is a one-cycle pulse on mclk; term may change at any time.
`timescale 1ns/1ps

module tc_scaler #(
	parameter int W = 15
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         reset,
	// Control
	input  wire logic         clear,
	input  wire logic         step,
	input  wire logic [W-1:0] term,
	// Result
	output logic              pulse
);

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	if (W < 1) begin : g_chk
		$error("tc_scaler: width must be at least one");
	end

	// Count steps; pass one pulse when the terminal value is reached
	always_comb begin
		cnt_d = cnt_q;
		pulse = 1'b0;
		if (clear) begin
			cnt_d = '0;
		end else if (step) begin
			if (cnt_q >= term) begin // Also recovers when term shrinks
				cnt_d = '0;
				pulse = 1'b1;
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	// Register the count
	always_ff @(posedge mclk) begin
		if (reset) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

endmodule // tc_scaler

// file: tc_timer.sv
// Eight/sixteen-bit timer/counter with prescaler, postscaler and AHB-Lite register slave.
// Assumes one 100 MHz mclk, synchronous active-high reset, and an asynchronous clock pin.
`timescale 1ns/1ps

module tc_timer (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        reset,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// External clock pin and power state
	input  wire logic        tmr_clk_pin,
	input  wire logic        sleep_mode,
	// Results
	output logic             timer_output_pulse,
	output logic             irq
);

	// Prescale ratio 2^select as a terminal count
	function automatic logic [tc_pkg::PRESCALE_W-1:0] pre_term(input logic [3:0] sel);
		logic [15:0] t;
		t = (16'h0001 << sel) - 16'h0001;
		return t[tc_pkg::PRESCALE_W-1:0];
	endfunction

	// Byte offset match of a registered address
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	// ---------------- Bus slave state ----------------
	tc_pkg::tc_bus_st_t bus_q, bus_d;
	logic [7:0]  addr_q, addr_d;
	logic        wr_q, wr_d;
	logic [31:0] rdata_q, rdata_d;
	logic        rdy_q, rdy_d;

	// ---------------- Timer state ----------------
	logic [7:0]  low_q, low_d;
	logic [7:0]  high_q, high_d;
	logic [7:0]  live_hi_q, live_hi_d;
	logic [7:0]  period_q, period_d;
	logic [7:0]  cfg0_q, cfg0_d;
	logic [7:0]  cfg1_q, cfg1_d;
	logic        out_q, out_d;
	logic        stat_q, stat_d;
	logic        mask_q, mask_d;
	logic        irq_q, irq_d;
	logic        pend_q, pend_d;
	logic [1:0]  qdiv_q, qdiv_d;

	// Pin synchroniser
	logic        s1_q, s2_q, s3_q, lvl_q;
	logic        lvl_d;

	// Decoded controls
	logic        acc_wr, acc_rd;
	logic        wr_low, wr_high, wr_cfg, rd_low, rd_stat;
	logic        wide, enable, async_sel;
	logic [2:0]  csel;
	logic        qcyc, pin_rise, pin_fall, src_ev;
	logic        pre_pulse, tick, out_ev, post_pulse, sc_clear;
	logic        match8;

	assign wide      = cfg0_q[tc_pkg::CZ_WIDE_BIT];
	assign enable    = cfg0_q[tc_pkg::CZ_ENABLE_BIT];
	assign async_sel = cfg1_q[tc_pkg::CO_ASYNC_BIT];
	assign csel      = cfg1_q[tc_pkg::CO_CSEL_LSB +: 3];

	// Outputs straight from flip-flops, hresp tied low
	assign hrdata             = rdata_q;
	assign hreadyout          = rdy_q;
	assign hresp              = 1'b0;
	assign timer_output_pulse = out_q;
	assign irq                = irq_q;

	// Bus phases: address taken, then one access cycle with hreadyout low
	always_comb begin
		bus_d   = bus_q;
		addr_d  = addr_q;
		wr_d    = wr_q;
		rdy_d   = 1'b1;
		rdata_d = rdata_q;
		case (bus_q)
			tc_pkg::BUS_IDLE: begin
				if (hsel && htrans[1] && hready) begin
					bus_d  = tc_pkg::BUS_ACCESS;
					addr_d = haddr[7:0];
					wr_d   = hwrite;
					rdy_d  = 1'b0;
				end
			end
			tc_pkg::BUS_ACCESS: begin
				bus_d = tc_pkg::BUS_IDLE;
				if (!wr_q) begin
					if (hit(addr_q, tc_pkg::OFS_COUNT_LOW)) begin
						rdata_d = {24'h000000, low_q};
					end else if (hit(addr_q, tc_pkg::OFS_COUNT_HIGH)) begin
						rdata_d = {24'h000000, high_q};
					end else if (hit(addr_q, tc_pkg::OFS_CONFIG_ZERO)) begin
						rdata_d = {24'h000000, cfg0_q[7:6], out_q, cfg0_q[4:0]};
					end else if (hit(addr_q, tc_pkg::OFS_CONFIG_ONE)) begin
						rdata_d = {24'h000000, cfg1_q};
					end else if (hit(addr_q, tc_pkg::OFS_INT_STATUS)) begin
						rdata_d = {31'h00000000, stat_q};
					end else if (hit(addr_q, tc_pkg::OFS_INT_MASK)) begin
						rdata_d = {31'h00000000, mask_q};
					end else begin
						rdata_d = 32'h00000000; // Unmapped reads as zero
					end
				end
			end
			default: begin
				bus_d = tc_pkg::BUS_IDLE;
			end
		endcase
	end

	// Register bus state
	always_ff @(posedge mclk) begin
		if (reset) begin
			bus_q   <= tc_pkg::BUS_IDLE;
			addr_q  <= 8'h00;
			wr_q    <= 1'b0;
			rdata_q <= 32'h00000000;
			rdy_q   <= 1'b1;
		end else begin
			bus_q   <= bus_d;
			addr_q  <= addr_d;
			wr_q    <= wr_d;
			rdata_q <= rdata_d;
			rdy_q   <= rdy_d;
		end
	end

	// Access strobes, valid in the access cycle
	assign acc_wr  = (bus_q == tc_pkg::BUS_ACCESS) && wr_q;
	assign acc_rd  = (bus_q == tc_pkg::BUS_ACCESS) && !wr_q;
	assign wr_low  = acc_wr && hit(addr_q, tc_pkg::OFS_COUNT_LOW);
	assign wr_high = acc_wr && hit(addr_q, tc_pkg::OFS_COUNT_HIGH);
	assign wr_cfg  = acc_wr && (hit(addr_q, tc_pkg::OFS_CONFIG_ZERO) || hit(addr_q, tc_pkg::OFS_CONFIG_ONE));
	assign rd_low  = acc_rd && hit(addr_q, tc_pkg::OFS_COUNT_LOW);
	assign rd_stat = acc_rd && hit(addr_q, tc_pkg::OFS_INT_STATUS);
	assign sc_clear = wr_low || wr_cfg;

	// Pin level accepted when second and third stages agree
	always_comb begin
		lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
	end

	// Three-stage pin synchroniser
	always_ff @(posedge mclk) begin
		if (reset) begin
			s1_q  <= 1'b0;
			s2_q  <= 1'b0;
			s3_q  <= 1'b0;
			lvl_q <= 1'b0;
		end else begin
			s1_q  <= tmr_clk_pin;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	assign pin_rise = lvl_d && !lvl_q;
	assign pin_fall = !lvl_d && lvl_q;

	// Quarter-rate instruction cycle divider
	always_comb begin
		qdiv_d = (qdiv_q == tc_pkg::INSTR_LAST) ? 2'h0 : qdiv_q + 2'h1;
	end
	assign qcyc = (qdiv_q == tc_pkg::INSTR_LAST) && !sleep_mode;

	// Clock source selection; internal sources stop in sleep
	always_comb begin
		if (csel == tc_pkg::CS_PIN_RISE) begin
			src_ev = pin_rise;
		end else if (csel == tc_pkg::CS_PIN_FALL) begin
			src_ev = pin_fall;
		end else if (csel == tc_pkg::CS_INSTR) begin
			src_ev = qcyc;
		end else if (csel == tc_pkg::CS_SYSTEM) begin
			src_ev = !sleep_mode;
		end else begin
			src_ev = 1'b0;
		end
	end

	// Prescaler, ratio 2^select, bypassed at zero
	tc_scaler #(
		.W(tc_pkg::PRESCALE_W)
	) u_pre (
		.mclk  (mclk),
		.reset (reset),
		.clear (sc_clear),
		.step  (src_ev && enable),
		.term  (pre_term(cfg1_q[3:0])),
		.pulse (pre_pulse)
	);

	// Async steps at once; sync waits for the instruction cycle and halts in sleep
	always_comb begin
		pend_d = pend_q;
		tick   = 1'b0;
		if (sc_clear || !enable) begin
			pend_d = 1'b0;
		end else if (async_sel) begin
			tick   = pre_pulse;
			pend_d = 1'b0;
		end else begin
			if (qcyc && (pend_q || pre_pulse)) begin
				tick   = 1'b1;
				pend_d = 1'b0;
			end else if (pre_pulse) begin
				pend_d = 1'b1;
			end
		end
	end

	assign match8 = (low_q == period_q);

	// Count, period and output pulse update
	always_comb begin
		low_d     = low_q;
		high_d    = high_q;
		live_hi_d = live_hi_q;
		period_d  = period_q;
		out_d     = out_q;
		out_ev    = 1'b0;
		if (tick) begin
			out_d = 1'b0; // Pulse lasts one prescaled period
			if (wide) begin
				{live_hi_d, low_d} = {live_hi_q, low_q} + 16'h0001;
				if ({live_hi_q, low_q} == 16'hffff) begin
					out_d  = 1'b1;
					out_ev = 1'b1;
				end
			end else if (match8) begin
				low_d    = 8'h00;
				period_d = high_q;
				out_d    = 1'b1;
				out_ev   = 1'b1;
			end else begin
				low_d = low_q + 8'h01;
			end
		end
		if (wr_low) begin
			low_d = hwdata[7:0];
			if (wide) begin
				live_hi_d = high_q;
			end
		end
		if (wr_high) begin
			high_d = hwdata[7:0];
		end else if (rd_low && wide) begin
			high_d = live_hi_q;
		end
	end

	// Configuration registers and mask
	always_comb begin
		cfg0_d = cfg0_q;
		cfg1_d = cfg1_q;
		mask_d = mask_q;
		if (acc_wr && hit(addr_q, tc_pkg::OFS_CONFIG_ZERO)) begin
			cfg0_d = hwdata[7:0];
		end
		if (acc_wr && hit(addr_q, tc_pkg::OFS_CONFIG_ONE)) begin
			cfg1_d = hwdata[7:0];
		end
		if (acc_wr && hit(addr_q, tc_pkg::OFS_INT_MASK)) begin
			mask_d = hwdata[0];
		end
	end

	// Postscaler, one flag event per N output events
	tc_scaler #(
		.W(tc_pkg::POSTSCALE_W)
	) u_post (
		.mclk  (mclk),
		.reset (reset),
		.clear (sc_clear),
		.step  (out_ev),
		.term  (cfg0_q[3:0]),
		.pulse (post_pulse)
	);

	// Sticky flag, cleared by status read; a new event wins over the clear
	always_comb begin
		stat_d = stat_q;
		if (rd_stat) begin
			stat_d = 1'b0;
		end
		if (post_pulse) begin
			stat_d = 1'b1;
		end
		irq_d = stat_d && mask_d;
	end

	// Register timer state
	always_ff @(posedge mclk) begin
		if (reset) begin
			low_q     <= tc_pkg::RST_COUNT_LOW;
			high_q    <= tc_pkg::RST_COUNT_HIGH;
			live_hi_q <= tc_pkg::RST_COUNT_LOW;
			period_q  <= tc_pkg::RST_COUNT_HIGH;
			cfg0_q    <= tc_pkg::RST_CONFIG;
			cfg1_q    <= tc_pkg::RST_CONFIG;
			out_q     <= 1'b0;
			stat_q    <= 1'b0;
			mask_q    <= 1'b0;
			irq_q     <= 1'b0;
			pend_q    <= 1'b0;
			qdiv_q    <= 2'h0;
		end else begin
			low_q     <= low_d;
			high_q    <= high_d;
			live_hi_q <= live_hi_d;
			period_q  <= period_d;
			cfg0_q    <= cfg0_d;
			cfg1_q    <= cfg1_d;
			out_q     <= out_d;
			stat_q    <= stat_d;
			mask_q    <= mask_d;
			irq_q     <= irq_d;
			pend_q    <= pend_d;
			qdiv_q    <= qdiv_d;
		end
	end

endmodule // tc_timer

// file: tc_timer_monitor.sv
// Assertions on the timer's bus handshake, reset state and interrupt mask.
// Sees only tc_timer ports; bound at the foot of this file.
`timescale 1ns/1ps
module tc_monitor (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        reset,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Results
	input wire logic        timer_output_pulse,
	input wire logic        irq
);
	logic [7:0] a_q, a_d;
	logic       w_q, w_d;
	logic       m_q, m_d;
	logic       en_q, en_d;
	logic       tk;
	logic       wacc;
	// Track the transfer in flight, shadow mask and enable
	always_comb begin
		tk   = hsel && htrans[1] && hready;
		wacc = !hreadyout && w_q;
		a_d  = tk ? haddr[7:0] : a_q;
		w_d  = tk ? hwrite : w_q;
		m_d  = (wacc && a_q == tc_pkg::OFS_INT_MASK) ? hwdata[0] : m_q;
		en_d = (wacc && a_q == tc_pkg::OFS_CONFIG_ZERO) ? hwdata[tc_pkg::CZ_ENABLE_BIT] : en_q;
	end
	// Register the shadows
	always_ff @(posedge mclk) begin
		if (reset) begin
			{a_q, w_q, m_q, en_q} <= '0;
		end else begin
			{a_q, w_q, m_q, en_q} <= {a_d, w_d, m_d, en_d};
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// Okay response, one wait cycle per transfer, read data, reset state, mask and idle pulse rules
	okay_resp_a: assert property (hresp == 1'b0) else $error("hresp not okay");
	one_wait_a: assert property (tk |=> !hreadyout ##1 hreadyout) else $error("wait not one cycle");
	stray_wait_a: assert property (!tk |=> hreadyout) else $error("wait without transfer");
	read_hold_a: assert property (!($rose(hreadyout) && !w_q) |-> $stable(hrdata)) else $error("hrdata moved");
	unmapped_zero_a: assert property ($rose(hreadyout) && !w_q && a_q > tc_pkg::OFS_INT_MASK |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
	reset_quiet_a: assert property (disable iff (1'b0) reset |=> hreadyout && !irq && !timer_output_pulse
		&& hrdata == 32'h0) else $error("outputs not reset");
	masked_quiet_a: assert property (!m_q |-> !irq) else $error("irq while masked");
	idle_pulse_a: assert property (!en_q [*4] |=> !$rose(timer_output_pulse)) else $error("pulse idle");
	// Main scenarios
	pulse_c: cover property ($rose(timer_output_pulse));
	irq_c: cover property ($rose(irq));
	read_c: cover property ($rose(hreadyout) && !w_q);
endmodule // tc_monitor

bind tc_timer tc_monitor i_mon (.mclk, .reset, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
	.hreadyout, .hresp, .timer_output_pulse, .irq);
